// ===== cgi_pkg.sv
// Package: register map, field positions and carrier types of the global interrupt flag block
package cgi_pkg;
   localparam int NUM_MBX = 32;
   localparam int LEGACY_MBX = 16;
   localparam int NUM_LINES = 2;
   localparam int ADDR_W = 8;

   localparam logic [7:0] OFS_FLAGS0 = 8'h00;
   localparam logic [7:0] OFS_FLAGS1 = 8'h04;
   localparam logic [7:0] OFS_GMASK = 8'h08;
   localparam logic [7:0] OFS_MBX_MASK = 8'h0C;
   localparam logic [7:0] OFS_MBX_LINE = 8'h10;

   localparam int BIT_GLOBAL_MAILBOX_FLAG = 15;
   localparam int BIT_ABORT_ACK_IRQ_FLAG = 14;
   localparam int BIT_WRITE_DENIED_FLAG = 13;
   localparam int BIT_WAKEUP_FLAG = 12;
   localparam int BIT_RX_LOST_FLAG = 11;
   localparam int BIT_BUS_OFF_FLAG = 10;
   localparam int BIT_ERROR_PASSIVE_FLAG = 9;
   localparam int BIT_WARNING_LEVEL_FLAG = 8;
   localparam int BIT_GIL = 2;
   localparam int BIT_I1EN = 1;
   localparam int BIT_I0EN = 0;
   localparam int MIV_W = 5;

   localparam logic [31:0] GMASK_RST = 32'h0000_0000;
   localparam logic [31:0] GMASK_WMASK = 32'h0000_7F07;
   localparam logic [31:0] FLAG_W1C_MASK = 32'h0000_3700;
   localparam logic [31:0] MBX_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] MBX_LINE_RST = 32'h0000_0000;

   // Status from the protocol engine and mailbox RAM, same clock
   typedef struct packed {
      logic wake_evt;
      logic bus_off;
      logic err_passive;
      logic warn_level;
      logic id_wr_stb;
      logic [4:0] id_wr_mbx;
   } cgi_can_status_t;

   // Per-mailbox state vectors
   typedef struct packed {
      logic [31:0] abort_ack;
      logic [31:0] tx_ack;
      logic [31:0] rx_pending;
      logic [31:0] rx_lost_evt;
      logic [31:0] enabled;
   } cgi_mbx_status_t;
endpackage : cgi_pkg

// ===== cgi_flags.sv
// Module: global interrupt flags, mailbox vector and two interrupt lines behind APB
//////////////////////////////////////////////////////////////////////////////
// Function
// - Abort ack flag sets; clears with ack bits
// - Identifier write on enabled mailbox sets flag
// - Wake-up flag sets on leaving sleep
// - Lost message on line-0 mailbox sets flag
// - Lost flag clears with pending bit clear
// - Bus-off entry sets bus-off flag
// - Error-passive entry sets error-passive flag
// - Warning level reached sets warning flag
// - Bits 7:5 reserved, writes change nothing
// - Vector holds mailbox number raising flag
// - Vector shows highest pending, 31 highest
// - Legacy mode uses four vector bits
// - Legacy mode ignores mailboxes 16 to 31 for mailbox flag and vector
// - Vector undefined when nothing pending
// - Global line select picks flag copy; lost and mailbox flags follow mailbox line
// - Global mask bits 14:8 gate flag interrupts; mailbox flag is not gated by them, only by mailbox mask
//////////////////////////////////////////////////////////////////////////////
module cgi_flags (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cgi_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cgi_pkg::cgi_can_status_t can_status,
   input wire cgi_pkg::cgi_mbx_status_t mbx_status,
   input wire logic legacy_compat_mode,
   output logic [cgi_pkg::NUM_LINES-1:0] irq_line
);
   localparam int NL = cgi_pkg::NUM_LINES;

   logic [31:0] gmask_q;
   logic [31:0] mbx_mask_q;
   logic [31:0] mbx_line_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [NL-1:0] irq_q;
   logic [NL-1:0] abort_ack_irq_flag_q, write_denied_flag_q, wakeup_flag_q, rx_lost_flag_q, bus_off_flag_q, error_passive_flag_q, warning_level_flag_q, global_mailbox_flag_q;
   logic [NL-1:0][31:0] lost_q;
   logic [NL-1:0][cgi_pkg::MIV_W-1:0] miv_q;
   logic bus_off_prev_q, err_passive_prev_q, warn_prev_q;
   logic [31:0] abort_ack_prev_q;

   //////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, access phase always ready
   logic setup_ph;
   logic wr_en;
   logic addr_hit;
   assign setup_ph = psel & ~penable;
   assign wr_en = psel & penable & pready_q & pwrite;

   always_comb begin
      case (paddr)
         cgi_pkg::OFS_FLAGS0, cgi_pkg::OFS_FLAGS1, cgi_pkg::OFS_GMASK,
         cgi_pkg::OFS_MBX_MASK, cgi_pkg::OFS_MBX_LINE: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_ph;
         pslverr_q <= setup_ph & ~addr_hit;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Software-owned registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gmask_q <= cgi_pkg::GMASK_RST;
         mbx_mask_q <= cgi_pkg::MBX_MASK_RST;
         mbx_line_q <= cgi_pkg::MBX_LINE_RST;
      end else if (wr_en) begin
         if (paddr == cgi_pkg::OFS_GMASK) begin
            gmask_q <= pwdata & cgi_pkg::GMASK_WMASK;
         end
         if (paddr == cgi_pkg::OFS_MBX_MASK) begin
            mbx_mask_q <= pwdata;
         end
         if (paddr == cgi_pkg::OFS_MBX_LINE) begin
            mbx_line_q <= pwdata;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Event detection
   logic [31:0] aa_rise;
   logic wd_evt, bo_rise, ep_rise, wl_rise;
   logic [NL-1:0] gsel;
   logic [NL-1:0][31:0] w1c;
   logic [NL-1:0][31:0] line_sel;
   logic [NL-1:0][31:0] line_mif;
   logic [31:0] mif;

   assign aa_rise = mbx_status.abort_ack & ~abort_ack_prev_q;
   assign wd_evt = can_status.id_wr_stb & mbx_status.enabled[can_status.id_wr_mbx];
   // Entry into a state, not the level, sets the flag so W1C can stick
   assign bo_rise = can_status.bus_off & ~bus_off_prev_q;
   assign ep_rise = can_status.err_passive & ~err_passive_prev_q;
   assign wl_rise = can_status.warn_level & ~warn_prev_q;
   assign mif = (mbx_status.tx_ack | mbx_status.rx_pending) & mbx_mask_q &
                (legacy_compat_mode ? 32'h0000_FFFF : 32'hFFFF_FFFF);

   always_comb begin
      for (int l = 0; l < NL; l++) begin
         gsel[l] = (gmask_q[cgi_pkg::BIT_GIL] == l[0]);
         line_sel[l] = l[0] ? mbx_line_q : ~mbx_line_q;
         line_mif[l] = mif & line_sel[l];
         w1c[l] = (wr_en && paddr == (l[0] ? cgi_pkg::OFS_FLAGS1 : cgi_pkg::OFS_FLAGS0)) ?
                  (pwdata & cgi_pkg::FLAG_W1C_MASK) : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_ack_prev_q <= 32'h0000_0000;
         bus_off_prev_q <= 1'b0;
         err_passive_prev_q <= 1'b0;
         warn_prev_q <= 1'b0;
      end else begin
         abort_ack_prev_q <= mbx_status.abort_ack;
         bus_off_prev_q <= can_status.bus_off;
         err_passive_prev_q <= can_status.err_passive;
         warn_prev_q <= can_status.warn_level;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Sticky flags, one copy per line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_ack_irq_flag_q <= '0;
         write_denied_flag_q <= '0;
         wakeup_flag_q <= '0;
         bus_off_flag_q <= '0;
         error_passive_flag_q <= '0;
         warning_level_flag_q <= '0;
      end else begin
         for (int l = 0; l < NL; l++) begin
            // cleared only as ack bits clear
            abort_ack_irq_flag_q[l] <= (gsel[l] & (|aa_rise)) | (abort_ack_irq_flag_q[l] & (|mbx_status.abort_ack));
            write_denied_flag_q[l] <= (gsel[l] & wd_evt) | (write_denied_flag_q[l] & ~w1c[l][cgi_pkg::BIT_WRITE_DENIED_FLAG]);
            wakeup_flag_q[l] <= (gsel[l] & can_status.wake_evt) | (wakeup_flag_q[l] & ~w1c[l][cgi_pkg::BIT_WAKEUP_FLAG]);
            bus_off_flag_q[l] <= (gsel[l] & bo_rise) | (bus_off_flag_q[l] & ~w1c[l][cgi_pkg::BIT_BUS_OFF_FLAG]);
            error_passive_flag_q[l] <= (gsel[l] & ep_rise) | (error_passive_flag_q[l] & ~w1c[l][cgi_pkg::BIT_ERROR_PASSIVE_FLAG]);
            warning_level_flag_q[l] <= (gsel[l] & wl_rise) | (warning_level_flag_q[l] & ~w1c[l][cgi_pkg::BIT_WARNING_LEVEL_FLAG]);
         end
      end
   end

   // Lost-message tracking per mailbox so the flag follows its own pending bit
   logic [NL-1:0][31:0] lost_d;
   always_comb begin
      for (int l = 0; l < NL; l++) begin
         // overflow on mailbox routed to this line
         lost_d[l] = (mbx_status.rx_lost_evt & line_sel[l]) | (lost_q[l] & mbx_status.rx_pending);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost_q <= '0;
         rx_lost_flag_q <= '0;
      end else begin
         lost_q <= lost_d;
         for (int l = 0; l < NL; l++) begin
            rx_lost_flag_q[l] <= |lost_d[l];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Mailbox vector: plain priority encode, so it holds while its source stays the highest pending
   function automatic logic [cgi_pkg::MIV_W-1:0] top_mbx(input logic [31:0] v);
      logic [cgi_pkg::MIV_W-1:0] r;
      r = '0;
      for (int i = 0; i < cgi_pkg::NUM_MBX; i++) begin
         if (v[i]) begin
            r = i[cgi_pkg::MIV_W-1:0];
         end
      end
      return r;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miv_q <= '0;
         global_mailbox_flag_q <= '0;
      end else begin
         for (int l = 0; l < NL; l++) begin
            global_mailbox_flag_q[l] <= |line_mif[l];
            if (|line_mif[l]) begin
               // bit 4 stays zero in legacy mode
               miv_q[l] <= top_mbx(line_mif[l]);
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read-back image and interrupt lines
   logic [NL-1:0][31:0] flags_img;
   logic [NL-1:0] line_en;
   logic [NL-1:0] irq_d;
   always_comb begin
      for (int l = 0; l < NL; l++) begin
         flags_img[l] = 32'h0000_0000;
         flags_img[l][cgi_pkg::BIT_GLOBAL_MAILBOX_FLAG] = global_mailbox_flag_q[l];
         flags_img[l][cgi_pkg::BIT_ABORT_ACK_IRQ_FLAG] = abort_ack_irq_flag_q[l];
         flags_img[l][cgi_pkg::BIT_WRITE_DENIED_FLAG] = write_denied_flag_q[l];
         flags_img[l][cgi_pkg::BIT_WAKEUP_FLAG] = wakeup_flag_q[l];
         flags_img[l][cgi_pkg::BIT_RX_LOST_FLAG] = rx_lost_flag_q[l];
         flags_img[l][cgi_pkg::BIT_BUS_OFF_FLAG] = bus_off_flag_q[l];
         flags_img[l][cgi_pkg::BIT_ERROR_PASSIVE_FLAG] = error_passive_flag_q[l];
         flags_img[l][cgi_pkg::BIT_WARNING_LEVEL_FLAG] = warning_level_flag_q[l];
         flags_img[l][cgi_pkg::MIV_W-1:0] = miv_q[l];
         line_en[l] = l[0] ? gmask_q[cgi_pkg::BIT_I1EN] : gmask_q[cgi_pkg::BIT_I0EN];
         irq_d[l] = line_en[l] & ((|(flags_img[l][cgi_pkg::BIT_ABORT_ACK_IRQ_FLAG:cgi_pkg::BIT_WARNING_LEVEL_FLAG] &
                    gmask_q[cgi_pkg::BIT_ABORT_ACK_IRQ_FLAG:cgi_pkg::BIT_WARNING_LEVEL_FLAG])) | global_mailbox_flag_q[l]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= '0;
      end else begin
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         case (paddr)
            cgi_pkg::OFS_FLAGS0: prdata_q <= flags_img[0];
            cgi_pkg::OFS_FLAGS1: prdata_q <= flags_img[1];
            cgi_pkg::OFS_GMASK: prdata_q <= gmask_q;
            cgi_pkg::OFS_MBX_MASK: prdata_q <= mbx_mask_q;
            cgi_pkg::OFS_MBX_LINE: prdata_q <= mbx_line_q;
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq_line = irq_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   wd_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      wd_evt && gmask_q[cgi_pkg::BIT_GIL] == 1'b0 |=> write_denied_flag_q[0])
      else $error("write denied flag not set");
   aa_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      abort_ack_irq_flag_q[0] && (|mbx_status.abort_ack) |=> abort_ack_irq_flag_q[0])
      else $error("abort flag dropped with ack bits set");
   wu_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      can_status.wake_evt && gsel[1] |=> wakeup_flag_q[1])
      else $error("wake flag not set");
   rml_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      lost_q[0] == 32'h0000_0000 && mbx_status.rx_lost_evt == 32'h0000_0000 |=> !rx_lost_flag_q[0])
      else $error("lost flag without lost mailbox");
   bo_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(can_status.bus_off) && gsel[0] |=> bus_off_flag_q[0])
      else $error("bus-off flag not set");
   ep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(can_status.err_passive) && gsel[0] |=> error_passive_flag_q[0])
      else $error("error-passive flag not set");
   wl_setwins_a: assert property (@(posedge pclk) disable iff (!presetn)
      wl_rise && gsel[0] && w1c[0][cgi_pkg::BIT_WARNING_LEVEL_FLAG] |=> warning_level_flag_q[0])
      else $error("clear beat a new warning event");
   rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      flags_img[0][7:5] == 3'b000 && flags_img[1][7:5] == 3'b000)
      else $error("reserved flag bits nonzero");
   miv_top_a: assert property (@(posedge pclk) disable iff (!presetn)
      line_mif[0][31] && !legacy_compat_mode |=> miv_q[0] == 5'h1F)
      else $error("vector not highest mailbox");
   miv_legacy_a: assert property (@(posedge pclk) disable iff (!presetn)
      legacy_compat_mode && $past(legacy_compat_mode) && (|line_mif[0]) |=> !miv_q[0][4])
      else $error("legacy vector uses bit 4");
   gil_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      can_status.wake_evt && gsel[1] && !wakeup_flag_q[0] |=> wakeup_flag_q[1] && !wakeup_flag_q[0])
      else $error("flag set in wrong copy");
   irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gmask_q[cgi_pkg::BIT_I0EN] |=> !irq_q[0])
      else $error("disabled line raised");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup_ph |=> pready_q) else $error("access phase not ready");
   aa_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|aa_rise) && gsel[0] |=> abort_ack_irq_flag_q[0])
      else $error("abort flag not set");
   wd_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      w1c[0][cgi_pkg::BIT_WRITE_DENIED_FLAG] && !(wd_evt && gsel[0]) |=> !write_denied_flag_q[0])
      else $error("write denied flag not cleared");
   wu_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !can_status.wake_evt && !wakeup_flag_q[0] |=> !wakeup_flag_q[0])
      else $error("wake flag set without wake");
   rml_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|(mbx_status.rx_lost_evt & line_sel[0])) |=> rx_lost_flag_q[0])
      else $error("lost flag not set");
   bo_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !can_status.bus_off && !bus_off_flag_q[0] |=> !bus_off_flag_q[0])
      else $error("bus-off flag set while bus-on");
   ep_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !can_status.err_passive && !error_passive_flag_q[0] |=> !error_passive_flag_q[0])
      else $error("error-passive flag set while active");
   wl_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !can_status.warn_level && !warning_level_flag_q[0] |=> !warning_level_flag_q[0])
      else $error("warning flag set below level");
   miv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(|line_mif[0]) |=> $stable(miv_q[0]))
      else $error("vector moved while idle");
endmodule // cgi_flags

// ===== cgi_host_model.sv
// Host CPU model: APB master that reaches the flag block registers
module cgi_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [cgi_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      hung = 1'b0;
   end

   // Bounded wait only guards against a dead slave
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      // Blocking so the caller sees a dead slave at once
      if (i == 16) hung = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // cgi_host_model

// ===== can_global_interrupt_flags_tb.sv
// Testbench: events, clears, line routing and vector of the flag block
module can_global_interrupt_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, err, legacy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [1:0] irq;
   logic [4:0] m;
   cgi_pkg::cgi_can_status_t cs;
   cgi_pkg::cgi_mbx_status_t ms;
   int n_errors, checked;

   cgi_flags cgi_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .can_status(cs), .mbx_status(ms), .legacy_compat_mode(legacy), .irq_line(irq));
   cgi_host_model cgi_host_model_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cgi_host_model_inst.xfer(w, a, d, rd, err);
      if (hung === 1'b1) begin
         n_errors++;
         finish_test();
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Raise one status event; pulses drop after one cycle, levels stay
   task automatic pulse(input int k);
      @(posedge pclk);
      case (k)
         0: cs.warn_level <= 1'b1;
         1: cs.err_passive <= 1'b1;
         2: cs.bus_off <= 1'b1;
         3: cs.wake_evt <= 1'b1;
         default: cs.id_wr_stb <= 1'b1;
      endcase
      @(posedge pclk);
      cs.wake_evt <= 1'b0;
      cs.id_wr_stb <= 1'b0;
   endtask

   function automatic int fbit(input int k);
      return (k < 3) ? 8 + k : 9 + k;
   endfunction

   function automatic logic [31:0] top(input logic [31:0] x, input logic lg);
      top = 32'h0000_8000;
      for (int i = 0; i < (lg ? 16 : 32); i++) begin
         if (x[i]) top[4:0] = 5'(i);
      end
   endfunction

   initial begin
      repeat (60000) @(posedge pclk);
      n_errors++;
      finish_test();
   end

   initial begin
      presetn = 1'b0;
      cs = '0;
      ms = '0;
      legacy = 1'b0;
      n_errors = 0;
      checked = 0;
      void'($urandom(32'h8149));
      cyc(10);
      presetn <= 1'b1;
      rdchk("flags0 rst", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
      bus(1'b1, cgi_pkg::OFS_GMASK, 32'hFFFF_FFFB);
      rdchk("gmask", cgi_pkg::OFS_GMASK, 32'h0000_7F03);
      bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_00E0);
      rdchk("reserved", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
      for (int k = 0; k < 5; k++) begin
         if (k == 4) begin
            m = 5'($urandom_range(31, 0));
            cs.id_wr_mbx <= m;
            ms.enabled <= ~(32'h0000_0001 << m);
            pulse(4);
            cyc(2);
            rdchk("id wr off", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
            ms.enabled <= 32'h0000_0001 << m;
         end
         pulse(k);
         rdchk("evt flag", cgi_pkg::OFS_FLAGS0, 32'h0000_0001 << fbit(k));
         chk("irq set", 32'h0000_0001, {30'h0, irq});
         rdchk("copy1", cgi_pkg::OFS_FLAGS1, 32'h0000_0000);
         cs <= '0;
         bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_0001 << fbit(k));
         cyc(2);
         rdchk("cleared", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
         chk("irq clr", 32'h0000_0000, {30'h0, irq});
      end
      // set beats clear: re-raise warning at the clearing edge
      pulse(0);
      cyc(1);
      cs <= '0;
      cyc(1);
      fork
         bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_0100);
         begin
            cyc(2);
            cs.warn_level <= 1'b1;
         end
      join
      rdchk("set wins", cgi_pkg::OFS_FLAGS0, 32'h0000_0100);
      cs <= '0;
      bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_0100);
      bus(1'b1, cgi_pkg::OFS_GMASK, 32'h0000_0003);
      pulse(3);
      cyc(3);
      chk("irq masked", 32'h0000_0000, {30'h0, irq});
      bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_1000);
      bus(1'b1, cgi_pkg::OFS_GMASK, 32'h0000_7F07);
      pulse(3);
      cyc(3);
      chk("irq line1", 32'h0000_0002, {30'h0, irq});
      rdchk("gil1 c1", cgi_pkg::OFS_FLAGS1, 32'h0000_1000);
      rdchk("gil1 c0", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
      bus(1'b1, cgi_pkg::OFS_FLAGS1, 32'h0000_1000);
      bus(1'b1, cgi_pkg::OFS_GMASK, 32'h0000_7F03);
      ms.abort_ack <= 32'h0000_0001 << m;
      cyc(2);
      rdchk("abort", cgi_pkg::OFS_FLAGS0, 32'h0000_4000);
      bus(1'b1, cgi_pkg::OFS_FLAGS0, 32'h0000_4000);
      rdchk("abort ro", cgi_pkg::OFS_FLAGS0, 32'h0000_4000);
      ms.abort_ack <= '0;
      cyc(2);
      rdchk("abort clr", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, cgi_pkg::OFS_MBX_LINE, s ? 32'h0000_0001 << m : 32'h0000_0000);
         ms.rx_pending <= 32'h0000_0001 << m;
         ms.rx_lost_evt <= 32'h0000_0001 << m;
         @(posedge pclk);
         ms.rx_lost_evt <= '0;
         cyc(1);
         rdchk("lost", cgi_pkg::OFS_FLAGS0, s ? 32'h0000_0000 : 32'h0000_0800);
         rdchk("lost c1", cgi_pkg::OFS_FLAGS1, s ? 32'h0000_0800 : 32'h0000_0000);
         ms.rx_pending <= '0;
         cyc(2);
         rdchk("lost clr", cgi_pkg::OFS_FLAGS0, 32'h0000_0000);
      end
      bus(1'b1, cgi_pkg::OFS_MBX_LINE, 32'h0000_0000);
      bus(1'b1, cgi_pkg::OFS_MBX_MASK, 32'hFFFF_FFFF);
      for (int j = 0; j < 10; j++) begin
         v = (j == 0) ? 32'h8000_0001 : (j == 1) ? 32'hFFFF_8001 : ($urandom() | 32'h0000_0001);
         ms.tx_ack <= v;
         legacy <= j[0];
         cyc(2);
         rdchk("vector", cgi_pkg::OFS_FLAGS0, top(v, j[0]));
      end
      ms.tx_ack <= 32'h0000_0005;
      legacy <= 1'b0;
      cyc(2);
      rdchk("vec drop", cgi_pkg::OFS_FLAGS0, 32'h0000_8002);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
      chk("unmapped", 32'h0000_0000, rd);
      finish_test();
   end
endmodule // can_global_interrupt_flags_tb
